// ### inc/flash_selfprog_map.svh
// Purpose: Offsets, fields, reset values and timing of the sequencer.
// Assumes: Wishbone byte addresses, 32-bit data words.
// Notes: Definitions only.
`ifndef FLASH_SELFPROG_MAP_SVH
`define FLASH_SELFPROG_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_PTR 8'h04
`define REG_DATA 8'h08
`define REG_EXEC 8'h0C
`define REG_LOCK 8'h10
// ----------------------------------------
// Control fields and command codes
// ----------------------------------------
`define CTRL_EN 0
`define CTRL_REEN 4
`define CTRL_BUSY 6
`define CTRL_IE 7
`define CTRL_RESET 5'h00
`define CMD_LOAD 5'h01
`define CMD_ERASE 5'h03
`define CMD_WRITE 5'h05
`define CMD_LOCK 5'h09
`define CMD_REEN 5'h11
`define LOCK_RESET 6'h3F
`define ERASED_WORD 16'hFFFF
// ----------------------------------------
// Timing
// ----------------------------------------
`define ARM_WINDOW 3'h4
`define CLK_PERIOD_NS 100
`define PROG_MIN_NS 3700000
`define PROG_MAX_NS 4500000
`define PROG_MIN_CYC ((`PROG_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_MAX_CYC (`PROG_MAX_NS / `CLK_PERIOD_NS)
`endif

// ### inc/flash_selfprog_pkg.sv
// Purpose: Types shared by the self-programming sequencer.
// Assumes: Nothing.
// Notes: Constants live in the map header.
package flash_selfprog_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARMED = 2'b01,
		ST_BUSY = 2'b10
	} seq_state_t;
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_ERASE = 2'b01,
		OP_WRITE = 2'b10,
		OP_LOCK = 2'b11
	} op_kind_t;
endpackage

// ### design/flash_self_program_sequencer.sv
// Purpose: Flash self-programming sequencer behind a Wishbone slave.
// Assumes: EEPROM inputs come from logic on clk_i.
// Notes:
// Contract
// - Buffer loads accepted before or after erase.
// - Buffer slots load in any order.
// - Erase: pointer, code, store within four.
// - Erase uses only the page field.
// - Operations on protected section halt processor.
// - Load: pointer, data, code, store; slot by word.
// - Buffer cleared on write, reenable, reset.
// - EEPROM write during loading drops buffer.
// - Write: page in pointer, code, store.
// - Interrupt held while enable bit clear.
// - Erase or write blocks lower section reads.
// - Busy flag stays while section blocked.
// - Lock set: value in data, code, store.
// - Zero data bits program lock bits.
// - Lock programming blocks no section.
// - EEPROM write busy rejects all commands.
// - Armed bits clear without store in four.
// - Operations last the programming time.
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`include "flash_selfprog_map.svh"
module flash_self_program_sequencer #(
	parameter int WORD_BITS = 6,
	parameter int NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 448,
	parameter int PROG_CYCLES = `PROG_MIN_CYC
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	// EEPROM controller
	input wire logic eeprom_write_busy_flag_i,
	input wire logic eeprom_write_start_i,
	// Flash array side
	input wire logic [WORD_BITS-1:0] buf_rd_idx_i,
	output logic [15:0] buf_rd_data_o,
	output logic flash_erase_o,
	output logic flash_write_o,
	output logic [14-WORD_BITS:0] flash_page_o,
	output logic [5:0] lock_bits_o,
	// Processor side
	output logic cpu_halt_o,
	output logic rww_read_block_o,
	output logic spm_irq_o
);
	localparam int PAGE_WORDS = 1 << WORD_BITS;
	localparam int PW = 15 - WORD_BITS;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
		hit = (adr[7:2] == off[7:2]);
	endfunction
	logic take;
	logic wr;
	logic ctrl_wr;
	logic exec_wr;
	assign take = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = take && wb_we_i;
	assign ctrl_wr = wr && wb_sel_i[0] && hit(wb_adr_i, `REG_CTRL);
	assign exec_wr = wr && hit(wb_adr_i, `REG_EXEC);
	flash_selfprog_pkg::seq_state_t state_reg;
	flash_selfprog_pkg::op_kind_t op_reg;
	logic [4:0] ctrl_reg;
	logic ie_reg;
	logic busy_flag_reg;
	logic [15:0] ptr_reg;
	logic [15:0] data_reg;
	logic [2:0] arm_cnt_reg;
	logic [31:0] prog_cnt_reg;
	logic [5:0] lock_data_reg;
	logic [15:0] buf_mem [PAGE_WORDS];
	logic [PAGE_WORDS-1:0] buf_valid_reg;
	logic [WORD_BITS-1:0] word_sel;
	logic [PW-1:0] page_sel;
	logic eeprom_blocks;
	logic go;
	logic done;
	logic arm_timeout;
	assign word_sel = ptr_reg[WORD_BITS:1];
	assign page_sel = ptr_reg[15:WORD_BITS+1];
	assign eeprom_blocks = eeprom_write_busy_flag_i;
	assign go = exec_wr && state_reg == flash_selfprog_pkg::ST_ARMED && !eeprom_blocks;
	assign done = state_reg == flash_selfprog_pkg::ST_BUSY && prog_cnt_reg == PROG_CYCLES - 1;
	assign arm_timeout = state_reg == flash_selfprog_pkg::ST_ARMED && !go
		&& arm_cnt_reg == `ARM_WINDOW - 3'h1;

	// ----------------------------------------
	// Wishbone answer
	// ----------------------------------------
	// Ack comes one edge after the request is taken and drops the next edge.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else if (ce_i) begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (take && !wb_we_i) begin
			if (hit(wb_adr_i, `REG_CTRL)) begin
				wb_dat_o <= {24'h000000, ie_reg, busy_flag_reg, 1'b0, ctrl_reg};
			end else if (hit(wb_adr_i, `REG_PTR)) begin
				wb_dat_o <= {16'h0000, ptr_reg};
			end else if (hit(wb_adr_i, `REG_DATA)) begin
				wb_dat_o <= {16'h0000, data_reg};
			end else if (hit(wb_adr_i, `REG_EXEC)) begin
				wb_dat_o <= {28'h0000000, op_reg, state_reg};
			end else if (hit(wb_adr_i, `REG_LOCK)) begin
				wb_dat_o <= {26'h0000000, lock_bits_o};
			end else begin
				wb_dat_o <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------
	// Pointer and data registers
	// ----------------------------------------
	// Stored operands stay writable during an operation since the page is latched.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ptr_reg <= 16'h0000;
			data_reg <= 16'h0000;
		end else if (wr) begin
			if (hit(wb_adr_i, `REG_PTR)) begin
				if (wb_sel_i[0]) begin
					ptr_reg[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					ptr_reg[15:8] <= wb_dat_i[15:8];
				end
			end
			if (hit(wb_adr_i, `REG_DATA)) begin
				if (wb_sel_i[0]) begin
					data_reg[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					data_reg[15:8] <= wb_dat_i[15:8];
				end
			end
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= flash_selfprog_pkg::ST_IDLE;
			op_reg <= flash_selfprog_pkg::OP_NONE;
			ctrl_reg <= `CTRL_RESET;
			ie_reg <= 1'b0;
			arm_cnt_reg <= 3'h0;
			prog_cnt_reg <= 32'h00000000;
			flash_page_o <= '0;
			lock_data_reg <= `LOCK_RESET;
		end else if (ce_i) begin
			case (state_reg)
				flash_selfprog_pkg::ST_IDLE: begin
					// A busy EEPROM write locks the control register out.
					if (ctrl_wr && !eeprom_blocks) begin
						ctrl_reg <= wb_dat_i[4:0];
						ie_reg <= wb_dat_i[`CTRL_IE];
						arm_cnt_reg <= 3'h0;
						if (wb_dat_i[`CTRL_EN]) begin
							state_reg <= flash_selfprog_pkg::ST_ARMED;
						end
					end
				end
				flash_selfprog_pkg::ST_ARMED: begin
					arm_cnt_reg <= arm_cnt_reg + 3'h1;
					if (arm_timeout) begin
						ctrl_reg <= `CTRL_RESET;
						state_reg <= flash_selfprog_pkg::ST_IDLE;
					end else if (go) begin
						prog_cnt_reg <= 32'h00000000;
						case (ctrl_reg)
							`CMD_ERASE: begin
								flash_page_o <= page_sel;
								op_reg <= flash_selfprog_pkg::OP_ERASE;
								state_reg <= flash_selfprog_pkg::ST_BUSY;
							end
							`CMD_WRITE: begin
								flash_page_o <= page_sel;
								op_reg <= flash_selfprog_pkg::OP_WRITE;
								state_reg <= flash_selfprog_pkg::ST_BUSY;
							end
							`CMD_LOCK: begin
								lock_data_reg <= data_reg[5:0];
								op_reg <= flash_selfprog_pkg::OP_LOCK;
								state_reg <= flash_selfprog_pkg::ST_BUSY;
							end
							default: begin
								// Loads, re-enable and unknown codes finish at once.
								ctrl_reg <= `CTRL_RESET;
								state_reg <= flash_selfprog_pkg::ST_IDLE;
							end
						endcase
					end
				end
				flash_selfprog_pkg::ST_BUSY: begin
					prog_cnt_reg <= prog_cnt_reg + 32'h00000001;
					if (done) begin
						ctrl_reg <= `CTRL_RESET;
						op_reg <= flash_selfprog_pkg::OP_NONE;
						state_reg <= flash_selfprog_pkg::ST_IDLE;
					end
				end
				default: begin
					state_reg <= flash_selfprog_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Temporary page buffer
	// ----------------------------------------
	// Cleared slots read as erased flash, so only the valid mask is reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			buf_valid_reg <= '0;
		end else if (ce_i) begin
			if (go && ctrl_reg == `CMD_LOAD) begin
				buf_valid_reg[word_sel] <= 1'b1;
			end
			if (done && op_reg == flash_selfprog_pkg::OP_WRITE) begin
				buf_valid_reg <= '0;
			end
			if (ctrl_wr && !eeprom_blocks && wb_dat_i[`CTRL_REEN]
				&& state_reg == flash_selfprog_pkg::ST_IDLE) begin
				buf_valid_reg <= '0;
			end
			if (eeprom_write_start_i && buf_valid_reg != '0) begin
				buf_valid_reg <= '0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (ce_i && go && ctrl_reg == `CMD_LOAD) begin
			buf_mem[word_sel] <= data_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			buf_rd_data_o <= `ERASED_WORD;
		end else if (ce_i) begin
			buf_rd_data_o <= buf_valid_reg[buf_rd_idx_i] ? buf_mem[buf_rd_idx_i] : `ERASED_WORD;
		end
	end

	// ----------------------------------------
	// Lock bits
	// ----------------------------------------
	// Lock bits only move toward programmed; only reset restores them.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_bits_o <= `LOCK_RESET;
		end else if (ce_i && done && op_reg == flash_selfprog_pkg::OP_LOCK) begin
			lock_bits_o <= lock_bits_o & lock_data_reg;
		end
	end

	// ----------------------------------------
	// Section blocking and status
	// ----------------------------------------
	logic start_rw;
	logic start_halt;
	assign start_rw = go && (ctrl_reg == `CMD_ERASE || ctrl_reg == `CMD_WRITE);
	assign start_halt = start_rw && 32'(page_sel) >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rww_read_block_o <= 1'b0;
			cpu_halt_o <= 1'b0;
			flash_erase_o <= 1'b0;
			flash_write_o <= 1'b0;
		end else if (ce_i) begin
			if (start_rw) begin
				rww_read_block_o <= 1'b1;
				cpu_halt_o <= start_halt;
				flash_erase_o <= ctrl_reg == `CMD_ERASE;
				flash_write_o <= ctrl_reg == `CMD_WRITE;
			end else if (done) begin
				rww_read_block_o <= 1'b0;
				cpu_halt_o <= 1'b0;
				flash_erase_o <= 1'b0;
				flash_write_o <= 1'b0;
			end
		end
	end

	// The busy flag outlives the operation until software re-enables the section.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_flag_reg <= 1'b0;
		end else if (ce_i) begin
			if (start_rw) begin
				busy_flag_reg <= 1'b1;
			end else if (go && ctrl_reg == `CMD_REEN && !rww_read_block_o) begin
				busy_flag_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			spm_irq_o <= 1'b0;
		end else if (ce_i) begin
			spm_irq_o <= ie_reg && !ctrl_reg[`CTRL_EN];
		end
	end
endmodule

// ### testbench/flash_selfprog_sva.sv
// Purpose: Port-level checks of the flash self-programming sequencer.
// Assumes: Bus master keeps classic single cycles.
// Notes: Operation length allows one cycle of slack either way.
`timescale 1ns/100ps
`include "flash_selfprog_map.svh"
module flash_selfprog_sva #(
	parameter int WORD_BITS = 6,
	parameter int NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 448,
	parameter int PROG_CYCLES = 20
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus and inputs
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic wb_ack_o,
	input wire logic eeprom_write_busy_flag_i,
	// Outputs watched
	input wire logic flash_erase_o,
	input wire logic flash_write_o,
	input wire logic [14-WORD_BITS:0] flash_page_o,
	input wire logic [5:0] lock_bits_o,
	input wire logic cpu_halt_o,
	input wire logic rww_read_block_o,
	input wire logic spm_irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic op;
	int cnt;
	assign op = flash_erase_o | flash_write_o;
	// Counts how long one erase or write has run so far.
	always_ff @(posedge clk_i) begin
		if (rst_i || !op) cnt <= 0;
		else cnt <= cnt + 1;
	end
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
	endsequence
	sequence s_op_start;
		$rose(op);
	endsequence
	a_ack_one_cycle: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse after take");
	a_op_length: assert property ($fell(op) |-> cnt >= PROG_CYCLES - 1 && cnt <= PROG_CYCLES + 1)
		else $error("operation length wrong");
	a_halt_by_page: assert property (s_op_start |-> cpu_halt_o == (flash_page_o >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE))
		else $error("halt does not match page");
	a_op_blocks_read: assert property (op |-> rww_read_block_o)
		else $error("section not blocked during operation");
	a_busy_no_irq: assert property (op |-> !spm_irq_o)
		else $error("interrupt while operation runs");
	a_lock_no_block: assert property ($changed(lock_bits_o) |-> !rww_read_block_o && !cpu_halt_o)
		else $error("lock update blocked a section");
	a_lock_only_clear: assert property ((lock_bits_o & ~$past(lock_bits_o)) == 6'h00)
		else $error("lock bit returned to one");
	a_page_held: assert property (op && $past(op) |-> $stable(flash_page_o))
		else $error("page moved during operation");
	a_eeprom_refuse: assert property (s_take ##0 (wb_we_i && wb_adr_i == `REG_EXEC && eeprom_write_busy_flag_i && !op) |=> !op [*3])
		else $error("store accepted while eeprom busy");
endmodule

// ### testbench/cpu_model.sv
// Purpose: Processor core issuing register accesses as classic Wishbone.
// Assumes: Slave answers within fifty cycles.
// Notes: A wait that runs out ends the run through the bench.
`timescale 1ns/100ps
module cpu_model (
	// Clock and answer
	input wire logic clk_i,
	input wire logic wb_ack_i,
	input wire logic [31:0] wb_dat_i,
	// Request
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [7:0] wb_adr_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_dat_o
);
	initial begin
		{wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
	end
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk_i);
		{wb_cyc_o, wb_stb_o, wb_we_o, wb_sel_o} <= {1'b1, 1'b1, we, 4'hF};
		wb_adr_o <= a;
		wb_dat_o <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_i !== 1'b1 && n < 50);
		q = wb_dat_i;
		{wb_cyc_o, wb_stb_o} <= 2'b00;
		if (wb_ack_i !== 1'b1) begin
			tb_top.n_fail++;
			tb_top.wrap_up();
		end
	endtask
endmodule

// ### testbench/tb_top.sv
// Purpose: Self-checking bench of the flash self-programming sequencer.
// Assumes: Programming time shortened to twenty cycles.
// Notes: Each store follows its arming write back to back, except in the arm expiry and frozen arm tests.
`timescale 1ns/100ps
`include "flash_selfprog_map.svh"
module tb_top;
	localparam int PROG_CYCLES = 20;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce = 1'b1;
	logic ee_busy = 1'b0;
	logic ee_start = 1'b0;
	logic [5:0] idx = 6'h00;
	logic cyc, stb, we, ack, erase, write, halt, block, irq;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	logic [15:0] bdat;
	logic [8:0] page;
	logic [5:0] lock;
	int n_fail = 0;
	int n_checks = 0;
	always #50 clk_i = ~clk_i;
	flash_self_program_sequencer #(.PROG_CYCLES(PROG_CYCLES)) dut_u (.clk_i(clk_i),
		.rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
		.eeprom_write_busy_flag_i(ee_busy), .eeprom_write_start_i(ee_start),
		.buf_rd_idx_i(idx), .buf_rd_data_o(bdat), .flash_erase_o(erase),
		.flash_write_o(write), .flash_page_o(page), .lock_bits_o(lock),
		.cpu_halt_o(halt), .rww_read_block_o(block), .spm_irq_o(irq));
	cpu_model cpu_u (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
		.wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		cpu_u.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a);
		cpu_u.xfer(1'b0, a, 32'h0, q);
	endtask
	// The store must be taken within four cycles, so it follows at once.
	task automatic cmd(input logic [7:0] c);
		wr(`REG_CTRL, {24'h0, c});
		wr(`REG_EXEC, 32'h0);
	endtask
	task automatic load(input logic [5:0] s, input logic [15:0] d);
		wr(`REG_PTR, {25'h0, s, 1'b0});
		wr(`REG_DATA, {16'h0, d});
		cmd({3'h0, `CMD_LOAD});
	endtask
	task automatic bchk(input logic [5:0] s, input logic [15:0] e);
		idx <= s;
		repeat (3) @(posedge clk_i);
		chk("buffer slot", {16'h0, bdat}, {16'h0, e});
	endtask
	task automatic wait_done();
		int n;
		q = 32'h1;
		for (n = 0; n < 40 && q[0] !== 1'b0; n++) rd(`REG_CTRL);
		if (q[0] !== 1'b0) begin
			n_fail++;
			wrap_up();
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`REG_CTRL);
		chk("ctrl reset", q, 32'h0);
		rd(`REG_LOCK);
		chk("lock reset", q, 32'h3F);
		rd(8'h20);
		chk("unmapped", q, 32'h0);
		bchk(6'h05, `ERASED_WORD);
		$display("test reset done");
		load(6'h05, 16'hA5C3);
		load(6'h02, 16'h1234);
		bchk(6'h05, 16'hA5C3);
		bchk(6'h02, 16'h1234);
		$display("test load done");
		// Stray word and byte bits in the pointer must not move the page.
		wr(`REG_PTR, 32'hE17F);
		cmd(8'h83);
		rd(`REG_CTRL);
		chk("busy flag", q[6], 1'b1);
		chk("erase", {halt, block, erase}, 3'h7);
		chk("page", page, 9'd450);
		wait_done();
		bchk(6'h05, 16'hA5C3);
		chk("irq", irq, 1'b1);
		wr(`REG_PTR, 32'hE100);
		cmd({3'h0, `CMD_WRITE});
		rd(`REG_CTRL);
		chk("write", {halt, write}, 2'h3);
		wait_done();
		bchk(6'h02, `ERASED_WORD);
		cmd({3'h0, `CMD_REEN});
		rd(`REG_CTRL);
		chk("busy clear", q[7:6], 2'h0);
		chk("irq off", irq, 1'b0);
		$display("test page done");
		wr(`REG_DATA, 32'h00FA);
		wr(`REG_PTR, 32'h0001);
		cmd({3'h0, `CMD_LOCK});
		rd(`REG_CTRL);
		chk("lock block", {halt, block}, 2'h0);
		wait_done();
		rd(`REG_LOCK);
		chk("lock bits", q, 32'h3A);
		$display("test lock done");
		wr(`REG_CTRL, 32'h03);
		repeat (6) @(posedge clk_i);
		wr(`REG_EXEC, 32'h0);
		rd(`REG_CTRL);
		chk("arm expiry", {q[3:0], erase}, 5'h00);
		wr(`REG_PTR, 32'h0180);
		cmd({3'h0, `CMD_ERASE});
		rd(`REG_CTRL);
		chk("low erase", {halt, block, erase}, 3'h3);
		wait_done();
		// A frozen clock enable must also freeze the arming window.
		wr(`REG_CTRL, 32'h03);
		ce <= 1'b0;
		repeat (8) @(posedge clk_i);
		ce <= 1'b1;
		wr(`REG_EXEC, 32'h0);
		rd(`REG_CTRL);
		chk("frozen arm", {halt, block, erase}, 3'h3);
		wait_done();
		$display("test arm done");
		ee_busy <= 1'b1;
		cmd({3'h0, `CMD_ERASE});
		rd(`REG_CTRL);
		chk("eeprom busy", {q[3:0], erase}, 5'h00);
		ee_busy <= 1'b0;
		load(6'h01, 16'h0BAD);
		ee_start <= 1'b1;
		@(posedge clk_i);
		ee_start <= 1'b0;
		bchk(6'h01, `ERASED_WORD);
		load(6'h07, 16'h7777);
		wr(`REG_CTRL, {27'h0, `CMD_REEN});
		bchk(6'h07, `ERASED_WORD);
		load(6'h04, 16'h4444);
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		bchk(6'h04, `ERASED_WORD);
		$display("test clear done");
		wrap_up();
	end
endmodule
bind flash_self_program_sequencer flash_selfprog_sva #(.WORD_BITS(WORD_BITS),
	.NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE), .PROG_CYCLES(PROG_CYCLES)) sva_u (.clk_i(clk_i),
	.rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .eeprom_write_busy_flag_i(eeprom_write_busy_flag_i),
	.flash_erase_o(flash_erase_o), .flash_write_o(flash_write_o), .flash_page_o(flash_page_o),
	.lock_bits_o(lock_bits_o), .cpu_halt_o(cpu_halt_o), .rww_read_block_o(rww_read_block_o),
	.spm_irq_o(spm_irq_o));
